/* File: hdl/scs_clock_select.sv */
// How it works
// - select 11 passes direct input straight through.
// - select 10 with bypass runs prescaler.
// - prescaler divides crystal or internal source by factor.
// - factor one follows oscillator frequency and duty.
// - division factor reaches 1024 at most.
// - crystal bypass at factor one matches direct drive.
// - select 10 without bypass runs the pll.
// - select 00 passes the wakeup clock undivided.
module scs_clock_select
  import scs_pkg::*;
#(
  parameter int ADDR_W = 8 // axi address width
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  // clock sources, sampled levels
  input  wire logic              direct_clock_input,
  input  wire logic              crystal_input,
  input  wire logic              internal_clock_input,
  input  wire logic              wakeup_clock_input,
  // system clock level
  output logic                   sys_clk,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 4) begin : g_bad_addr
    $error("address too narrow for the register map");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  scs_cfg_type       shadow;      // as software last wrote it
  scs_cfg_type       next_shadow; // shadow after this write
  scs_cfg_type       act;         // configuration in force
  logic              aw_held;     // write address accepted
  logic [ADDR_W-1:0] aw_addr;     // held write address
  logic              w_held;      // write data accepted
  logic [31:0]       w_data;      // held write data
  logic [3:0]        w_strb;      // held byte strobes
  logic              wr_fire;     // both halves present, do the write
  logic              wr_err;      // write hit no register
  logic [31:0]       wr_word;     // merged register image
  logic              pending;     // shadow differs from act
  logic              new_low;     // incoming source sits low
  logic              apply;       // switch configuration now
  logic              osc_in;      // prescaler and pll input level
  logic              presc_out;   // prescaler clock level
  logic              pll_out;     // pll clock level
  logic              cand;        // level the selected source offers

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_word(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] sys_word(input scs_cfg_type c);
    logic [31:0] w;
    w = '0;
    w[SEL_LSB +: SEL_W] = c.sel;
    w[OSC_SRC_BIT]      = c.osc_internal;
    return w;
  endfunction

  function automatic logic [31:0] pll_word(input scs_cfg_type c);
    logic [31:0] w;
    w = '0;
    w[BYP_BIT]            = c.vco_bypass;
    w[IN_DIV_LSB +: IN_DIV_W] = c.in_div;
    w[MULT_LSB +: MULT_W]     = c.mult;
    w[K2_LSB +: K2_W]         = c.post_div;
    return w;
  endfunction

  function automatic logic [31:0] div_word(input scs_cfg_type c);
    logic [31:0] w;
    w = '0;
    w[OUT_DIV_LSB +: OUT_DIV_W] = c.out_div;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  // response slot must be free, so bvalid is never overwritten
  assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;

  // address and data are caught separately, in either order
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write decode; the status word takes no writes but answers okay
  always_comb begin
    next_shadow = shadow;
    wr_err      = 1'b0;
    wr_word     = 32'h00000000;
    if (aw_addr == ADDR_W'(OFS_SYSCFG)) begin
      wr_word            = merge_word(sys_word(shadow), w_data, w_strb);
      next_shadow.sel    = wr_word[SEL_LSB +: SEL_W];
      next_shadow.osc_internal = wr_word[OSC_SRC_BIT];
    end else if (aw_addr == ADDR_W'(OFS_PLLCFG)) begin
      wr_word            = merge_word(pll_word(shadow), w_data, w_strb);
      next_shadow.vco_bypass = wr_word[BYP_BIT];
      next_shadow.in_div   = wr_word[IN_DIV_LSB +: IN_DIV_W];
      next_shadow.mult     = wr_word[MULT_LSB +: MULT_W];
      next_shadow.post_div = wr_word[K2_LSB +: K2_W];
    end else if (aw_addr == ADDR_W'(OFS_DIVCFG)) begin
      wr_word            = merge_word(div_word(shadow), w_data, w_strb);
      next_shadow.out_div = wr_word[OUT_DIV_LSB +: OUT_DIV_W];
    end else if (aw_addr != ADDR_W'(OFS_STATUS)) begin
      wr_err             = 1'b1;
    end
  end

  // write response, held until the master takes it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // shadow configuration
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shadow <= CFG_RESET;
    end else if (wr_fire) begin
      shadow <= next_shadow;
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  // one cycle after the address is taken the data stands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(OFS_SYSCFG)) begin
        s_axi_rdata <= sys_word(shadow);
      end else if (s_axi_araddr == ADDR_W'(OFS_PLLCFG)) begin
        s_axi_rdata <= pll_word(shadow);
      end else if (s_axi_araddr == ADDR_W'(OFS_DIVCFG)) begin
        s_axi_rdata <= div_word(shadow);
      end else if (s_axi_araddr == ADDR_W'(OFS_STATUS)) begin
        // what is in force, not what was asked for
        s_axi_rdata <= (32'(act.sel) << ST_SEL_LSB)
                     | (32'(pending) << ST_PEND_BIT)
                     | (32'(sys_clk) << ST_CLK_BIT);
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // clean switchover
  // ----------------------------------------------------------------
  // a new configuration waits until the output is low and a raw
  // incoming source is low too, so no high phase is cut short except the first one from the prescaler at factor one.
  // limitation: a source stuck high holds the switch off for good.
  assign pending = (shadow != act);

  always_comb begin
    if (shadow.sel == SEL_DIRECT) begin
      new_low = ~direct_clock_input;
    end else if (shadow.sel == SEL_WAKEUP) begin
      new_low = ~wakeup_clock_input;
    end else begin
      new_low = 1'b1; // divided paths restart from low
    end
  end

  assign apply = pending & ~sys_clk & new_low;

  // configuration in force
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      act <= CFG_RESET;
    end else if (apply) begin
      act <= shadow;
    end
  end

  // ----------------------------------------------------------------
  // clock generators
  // ----------------------------------------------------------------
  // crystal or on-chip source feeds both prescaler and pll
  assign osc_in = act.osc_internal ? internal_clock_input
                                   : crystal_input;

  scs_prescaler #(
    .DIV_W        (OUT_DIV_W)
  ) u_prescaler (
    .core_clk     (core_clk),
    .rst          (rst),
    .restart      (apply),
    .clk_in       (osc_in),
    .out_div      (act.out_div),
    .out_div_load (shadow.out_div),
    .clk_out      (presc_out)
  );

  scs_pll_model u_pll (
    .core_clk (core_clk),
    .rst      (rst),
    .restart  (apply),
    .clk_in   (osc_in),
    .in_div   (act.in_div),
    .mult     (act.mult),
    .post_div (act.post_div),
    .clk_out  (pll_out)
  );

  // ----------------------------------------------------------------
  // source multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    case (act.sel)
      SEL_WAKEUP: cand = wakeup_clock_input;
      SEL_DIRECT: cand = direct_clock_input;
      SEL_OSC:    cand = act.vco_bypass ? presc_out
                                        : pll_out;
      default:    cand = 1'b0; // reserved code stops the clock
    endcase
  end

  // output register; forced low on the switch edge so the old
  // source cannot squeeze in a one-cycle high phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sys_clk <= 1'b0;
    end else begin
      sys_clk <= apply ? 1'b0 : cand;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_xtal_unity;
    !apply && act.sel == SEL_OSC && act.vco_bypass &&
    !act.osc_internal && act.out_div == '0;
  endsequence

  chk_direct_follow: assert property (
    (!apply && act.sel == SEL_DIRECT)
      |=> (sys_clk == $past(direct_clock_input))
  ) else $error("direct mode does not follow the direct input");

  chk_presc_mode: assert property (
    (!apply && act.sel == SEL_OSC && act.vco_bypass)
      |=> (sys_clk == $past(presc_out))
  ) else $error("prescaler mode not driving the system clock");

  chk_bypass_equiv: assert property (
    s_xtal_unity ##1 s_xtal_unity
      |=> (sys_clk == $past(crystal_input, 2))
  ) else $error("crystal bypass at one does not track the crystal");

  chk_pll_mode: assert property (
    (!apply && act.sel == SEL_OSC && !act.vco_bypass)
      |=> (sys_clk == $past(pll_out))
  ) else $error("pll mode not driving the system clock");

  chk_wakeup_follow: assert property (
    (!apply && act.sel == SEL_WAKEUP)
      |=> (sys_clk == $past(wakeup_clock_input))
  ) else $error("wakeup mode does not follow the wakeup clock");

  chk_switch_clean: assert property (
    apply |-> (!sys_clk ##1 (!sys_clk && act == $past(shadow)))
  ) else $error("switch taken while the clock was high");

  chk_reserved_low: assert property (
    (act.sel == SEL_RESERVED) |=> !sys_clk
  ) else $error("reserved select code let a clock through");

endmodule

/* File: hdl/scs_pkg.sv */
package scs_pkg;

  // ----------------------------------------------------------------
  // clock source select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_WAKEUP   = 2'h0; // low-frequency wakeup clock
  localparam logic [1:0] SEL_RESERVED = 2'h1; // no source, clock held low
  localparam logic [1:0] SEL_OSC      = 2'h2; // prescaler or pll
  localparam logic [1:0] SEL_DIRECT   = 2'h3; // direct clock input pin

  // ----------------------------------------------------------------
  // field widths
  // ----------------------------------------------------------------
  localparam int SEL_W          = 2;    // clock_source_select
  localparam int IN_DIV_W       = 4;    // pll_input_divider_field
  localparam int MULT_W         = 7;    // pll_multiplier_field
  localparam int K2_W           = 7;    // pll_output_divider_field
  localparam int OUT_DIV_W      = 10;   // output_divider_field
  localparam int OUT_FACTOR_MAX = 1024; // largest output_division_factor

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SYSCFG = 8'h00; // system_clock_config_register
  localparam logic [7:0] OFS_PLLCFG = 8'h04; // pll_config_register
  localparam logic [7:0] OFS_DIVCFG = 8'h08; // output divider register
  localparam logic [7:0] OFS_STATUS = 8'h0C; // active state, read only

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEL_LSB     = 0;  // syscfg: source select
  localparam int OSC_SRC_BIT = 4;  // syscfg: 1 = internal clock source
  localparam int BYP_BIT     = 0;  // pllcfg: vco_bypass_bit
  localparam int IN_DIV_LSB  = 4;  // pllcfg: input divider
  localparam int MULT_LSB    = 8;  // pllcfg: multiplier
  localparam int K2_LSB      = 16; // pllcfg: output divider
  localparam int OUT_DIV_LSB = 0;  // divcfg: output_divider_field
  localparam int ST_SEL_LSB  = 0;  // status: active source select
  localparam int ST_PEND_BIT = 4;  // status: switch pending
  localparam int ST_CLK_BIT  = 5;  // status: present system clock level

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // full clock configuration, travels as one word
  typedef struct packed {
    logic [SEL_W-1:0]     sel;          // clock_source_select
    logic                 osc_internal; // prescaler/pll input choice
    logic                 vco_bypass;   // vco_bypass_bit
    logic [IN_DIV_W-1:0]  in_div;       // pll_input_divider_field
    logic [MULT_W-1:0]    mult;         // pll_multiplier_field
    logic [K2_W-1:0]      post_div;     // pll_output_divider_field
    logic [OUT_DIV_W-1:0] out_div;      // output_divider_field
  } scs_cfg_type;

  // comes up on the wakeup clock, bypass set, all dividers at one
  localparam scs_cfg_type CFG_RESET = '{
    sel:          SEL_WAKEUP,
    osc_internal: 1'b0,
    vco_bypass:   1'b1,
    in_div:       4'h0,
    mult:         7'h00,
    post_div:     7'h00,
    out_div:      10'h000
  };

endpackage

/* File: hdl/scs_prescaler.sv */
module scs_prescaler
  import scs_pkg::*;
#(
  parameter int DIV_W = OUT_DIV_W // width of the divider field
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             restart,    // restart the count, output low
  input  wire logic             clk_in,     // sampled oscillator level
  input  wire logic [DIV_W-1:0] out_div,      // active divider field
  input  wire logic [DIV_W-1:0] out_div_load, // divider taking effect
  output logic                  clk_out     // divided clock level
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if ((2 ** DIV_W) < OUT_FACTOR_MAX) begin : g_bad_width
    $error("divider field too narrow for the largest factor");
  end

  logic             in_d;     // last sampled input level
  logic             rise;     // input rising edge
  logic [DIV_W-1:0] cnt;      // input periods into the output period
  logic [DIV_W-1:0] next_cnt; // count after this edge
  logic [DIV_W:0]   half;     // input periods spent high

  assign rise     = clk_in & ~in_d;
  assign next_cnt = (cnt >= out_div) ? '0 : cnt + 1'b1;
  assign half     = ({1'b0, out_div} + 1'b1) >> 1;

  // edge detector history
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_d <= 1'b0;
    end else begin
      in_d <= clk_in;
    end
  end

  // period counter, one output period per division factor inputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (restart) begin
      // preloaded so the first input edge opens a full high phase
      cnt <= out_div_load;
    end else if (rise) begin
      cnt <= next_cnt;
    end
  end

  // output level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_out <= 1'b0;
    end else if (restart) begin
      clk_out <= 1'b0;
    end else if (out_div == '0) begin
      // factor one: output copies the input, duty and all
      clk_out <= clk_in;
    end else if (rise) begin
      clk_out <= ({1'b0, next_cnt} < half);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_unity_follow: assert property (
    (!restart && out_div == '0) |=> (clk_out == $past(clk_in))
  ) else $error("factor one output does not follow input");

  chk_count_range: assert property (
    (!restart && $stable(out_div) && cnt <= out_div) |=> (cnt <= out_div)
  ) else $error("prescaler count ran past the divider value");

  chk_wrap_high: assert property (
    (!restart && rise && out_div != '0 && cnt == out_div)
      |=> (clk_out && cnt == '0)
  ) else $error("output period did not restart after a full count");

endmodule

/* File: hdl/scs_pll_model.sv */
module scs_pll_model
  import scs_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                restart,  // clear phase, output low
  input  wire logic                clk_in,   // sampled oscillator level
  input  wire logic [IN_DIV_W-1:0] in_div,   // P = in_div + 1
  input  wire logic [MULT_W-1:0]   mult,     // N = mult + 1
  input  wire logic [K2_W-1:0]     post_div, // K2 = post_div + 1
  output logic                     clk_out   // synthesised clock level
);

  // digital stand-in for the loop: two toggles per output period,
  // so the accumulator gains 2N per input period and sheds P*K2
  // per toggle. limitation: one toggle per core clock at most.
  localparam int ACC_W = 14;

  logic             in_d;     // last sampled input level
  logic             rise;     // input rising edge
  logic [11:0]      thresh;   // P * K2
  logic [8:0]       step;     // 2 * N
  logic [ACC_W-1:0] acc;      // phase accumulator
  logic [ACC_W:0]   sum;      // accumulator plus this edge's step, less P*K2 on a toggle
  logic             toggle;   // output changes this edge

  assign rise   = clk_in & ~in_d;
  // both factors widened first so P*K2 up to 2048 never overflows
  assign thresh = ({8'h00, in_div} + 12'h001) * ({5'h00, post_div} + 12'h001);
  assign step   = {({1'b0, mult} + 8'h01), 1'b0};
  assign toggle = ({1'b0, acc} >= {3'h0, thresh});
  assign sum    = {1'b0, acc} + (rise ? {6'h00, step} : 15'h0000)
                  - (toggle ? {3'h0, thresh} : 15'h0000);

  // edge detector history
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_d <= 1'b0;
    end else begin
      in_d <= clk_in;
    end
  end

  // accumulator saturates rather than wrap when N outruns P*K2
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc <= '0;
    end else if (restart) begin
      acc <= '0;
    end else if (sum[ACC_W]) begin
      acc <= '1;
    end else begin
      acc <= sum[ACC_W-1:0];
    end
  end

  // output level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_out <= 1'b0;
    end else if (restart) begin
      clk_out <= 1'b0;
    end else if (toggle) begin
      clk_out <= ~clk_out;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_pll_toggle: assert property (
    (!restart && toggle) |=> (clk_out != $past(clk_out))
  ) else $error("pll output missed a toggle");

endmodule

/* File: bench/scs_osc_model.sv */
module scs_osc_model (
  input  wire logic       core_clk,
  output logic      [3:0] lvl       // direct, crystal, internal, wakeup
);
  timeunit 1ns;
  timeprecision 1ps;
  // half periods in core cycles; all differ so a wrong pick shows
  localparam int HALF [4] = '{3, 2, 5, 7};
  int cnt [4] = '{default: 0};
  initial lvl = 4'h0;
  // ----------------------------------------------------------------
  // free-running sources, deaf to the core reset like real oscillators
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (cnt[i] == HALF[i] - 1) begin
        cnt[i] <= 0;
        lvl[i] <= ~lvl[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule

/* File: bench/scs_clock_select_test.sv */
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h not %h", $time, a, e); end end
module scs_clock_select_test
  import scs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst, sys_clk, lst;
  logic [3:0]  src, s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          error_cnt, compares, cnt, hcnt, per_q, hi_q, k, n;
  // rows: syscfg, pllcfg, divcfg, period, high time (0 = not checked)
  localparam int ROWS [8][5] = '{'{3, 1, 0, 6, 3}, '{2, 1, 0, 4, 2},
    '{18, 1, 0, 10, 5}, '{2, 1, 2, 12, 0}, '{18, 1, 1, 20, 0},
    '{2, 1, 1023, 4096, 0}, '{2, 16, 0, 8, 0}, '{0, 1, 0, 14, 7}};
  scs_osc_model scs_osc_model_i (.core_clk, .lvl(src));
  scs_clock_select scs_clock_select_i (.core_clk, .rst, .sys_clk,
    .direct_clock_input(src[0]), .crystal_input(src[1]),
    .internal_clock_input(src[2]), .wakeup_clock_input(src[3]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // period and high time of sys_clk, latched at each rising level
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    lst <= sys_clk;
    cnt <= cnt + 1;
    hcnt <= hcnt + int'(sys_clk);
    if (sys_clk && !lst) begin
      per_q <= cnt;
      hi_q <= hcnt;
      cnt <= 1;
      hcnt <= 1;
    end
  end
  task automatic complete_run();
    if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bready is held high throughout, so only the request side moves
  task automatic wr(input logic [7:0] a, input int d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int i = 0; i < 99; i++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    `CHK(s_axi_bresp, r)
  endtask
  task automatic rd(input logic [7:0] a, input int d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int i = 0; i < 99; i++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    `CHK(s_axi_rdata, 32'(d))
    `CHK(s_axi_rresp, r)
  endtask
  initial begin
    {rst, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(OFS_SYSCFG, 0, RESP_OKAY);
    rd(OFS_PLLCFG, 1, RESP_OKAY);
    rd(OFS_DIVCFG, 0, RESP_OKAY);
    for (int r = 0; r < 8; r++) begin
      wr(OFS_DIVCFG, ROWS[r][2], RESP_OKAY);
      wr(OFS_PLLCFG, ROWS[r][1], RESP_OKAY);
      wr(OFS_SYSCFG, ROWS[r][0], RESP_OKAY);
      // skip the switch-over period, then take a clean one; the
      // edge count lets a half-written configuration pass before the checked period
      repeat (20) @(posedge core_clk);
      for (k = 0, n = 0; n < 13000 && k < 3; n++) begin
        @(posedge core_clk);
        if (sys_clk === 1'b1 && lst === 1'b0) k++;
      end
      @(negedge core_clk);
      `CHK(per_q, ROWS[r][3])
      if (ROWS[r][4] != 0) `CHK(hi_q, ROWS[r][4])
    end
    // unmapped place and read-only status
    wr(8'h10, -1, RESP_SLVERR);
    rd(8'h10, 0, RESP_SLVERR);
    wr(OFS_STATUS, -1, RESP_OKAY);
    rd(OFS_SYSCFG, 0, RESP_OKAY);
    // reserved select stops the clock; status shows it in force
    wr(OFS_SYSCFG, 1, RESP_OKAY);
    repeat (30) @(posedge core_clk);
    `CHK(sys_clk, 1'b0)
    rd(OFS_STATUS, 1, RESP_OKAY);
    // reset in mid-run drops the clock and the configuration
    wr(OFS_SYSCFG, 3, RESP_OKAY);
    rst <= 1'b1;
    @(negedge core_clk);
    `CHK(sys_clk, 1'b0)
    @(posedge core_clk);
    rst <= 1'b0;
    rd(OFS_SYSCFG, 0, RESP_OKAY);
    complete_run();
  end
  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    complete_run();
  end
endmodule
